// ### design/bec_pkg.sv
/*
 * Shared constants for the banked data-space and nonvolatile write control
 * pair: data-space addresses, field positions, reset values, timing counts,
 * and the command registers of the core-side controller.
 * Assumes an 8-bit data space with 8-bit addresses and one system clock.
 */
package bec_pkg;

    // Data-space map of the device
    localparam logic [7:0] BANK_SEL_ADDR = 8'he8;
    localparam logic [7:0] NVM_CTL_ADDR = 8'hea;
    localparam logic [1:0] BANK_REGION_TOP = 2'h0; // Address bits 7:6

    // Bank select codes
    localparam logic [7:0] SEL_NONE = 8'h00;
    localparam logic [7:0] SEL_NVM = 8'h01;
    localparam logic [7:0] SEL_RAM2 = 8'h10;
    localparam int RAM2_SEL_BIT = 4;
    localparam int NVM_SEL_BIT = 0;

    // Field positions of the nonvolatile control register
    localparam int CTL_ENA_BIT = 0;
    localparam int CTL_BUSY_BIT = 1;
    localparam int CTL_ROWMODE_BIT = 2;
    localparam int CTL_START_BIT = 3;
    localparam int CTL_STBY_BIT = 6;

    // Reset values
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Geometry
    localparam int PAGE_BYTES = 64;
    localparam int ROW_BYTES = 8;

    // Programming cycle length in system clocks
    localparam int unsigned PROG_CYCLES = 500;

    // Controller register offsets
    localparam logic [2:0] H_ADDR = 3'h0;
    localparam logic [2:0] H_DATA = 3'h1;
    localparam logic [2:0] H_CMD = 3'h2;
    localparam logic [2:0] H_STATUS = 3'h3;
    localparam logic [2:0] H_RDATA = 3'h4;
    localparam logic [2:0] H_BANK_IMG = 3'h5;
    localparam logic [2:0] H_CTL_IMG = 3'h6;

    // Controller command and status bits
    localparam int CMD_RD_BIT = 0;
    localparam int CMD_WR_BIT = 1;
    localparam int ST_PEND_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_REFUSED_BIT = 2;

    typedef enum logic [1:0]
    {
        BEC_IDLE = 2'b00,
        BEC_ISSUE = 2'b01,
        BEC_CAPT = 2'b10
    } bec_host_state_e;

endpackage

// ### design/bec_bus_if.sv
/*
 * Data-space bus between the processor core end and the banked memory
 * device end. Write and read strobes last one cycle; read data stand in
 * the cycle after the read strobe. Both ends share one clock.
 */
interface bec_bus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;

    modport dev
    (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata
    );

    modport host
    (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata
    );
endinterface

// ### design/bec_nvm_dev.sv
/*
 * Device end: bank select register, second RAM page, nonvolatile page with
 * byte and row programming, control register and busy timer.
 * Assumes a core on the same clock driving one-cycle strobes on the bus.
 */
module bec_nvm_dev
#(
    parameter int unsigned PROG_CYCLES = bec_pkg::PROG_CYCLES
)
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    bec_bus_if.dev bus,
    output logic nvm_busy_out,
    output logic nvm_standby_out,
    output logic [7:0] bank_select_out
);

    localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

    logic [7:0] bank_select_reg;
    logic standby_reg;
    logic prog_en_reg;
    logic row_mode_reg;
    logic row_start_reg;
    logic busy_reg;
    logic [15:0] prog_cnt_reg;
    logic row_cycle_reg;
    logic [5:0] byte_addr_reg;
    logic [7:0] byte_data_reg;
    logic row_held_reg;
    logic [2:0] row_addr_reg;
    logic [7:0] row_mask_reg;
    logic [7:0] row_latch_reg [bec_pkg::ROW_BYTES];
    logic [7:0] ram_reg [bec_pkg::PAGE_BYTES];
    logic [7:0] nvm_reg [bec_pkg::PAGE_BYTES];
    logic [7:0] rdata_reg;

    logic in_bank;
    logic ram_sel;
    logic nvm_sel;
    logic nvm_live;
    logic wr_ram;
    logic wr_nvm;
    logic wr_ctl;
    logic byte_go;
    logic start_go;
    logic row_enter;
    logic row_quit;
    logic row_load;
    logic prog_done;
    logic [5:0] offs;

    // Address decode and page selection
    assign offs = bus.addr[5:0];
    assign in_bank = bus.addr[7:6] == bec_pkg::BANK_REGION_TOP;
    // Only the exact codes map; mixed codes map nothing
    assign ram_sel = bank_select_reg == bec_pkg::SEL_RAM2;
    assign nvm_sel = bank_select_reg == bec_pkg::SEL_NVM;
    assign nvm_live = nvm_sel && !standby_reg && !busy_reg;
    assign wr_ram = bus.wr && in_bank && ram_sel;
    assign wr_nvm = bus.wr && in_bank && nvm_live;
    assign wr_ctl = bus.wr && bus.addr == bec_pkg::NVM_CTL_ADDR
        && !busy_reg;

    // Write classification
    assign byte_go = wr_nvm && prog_en_reg && !row_mode_reg;
    assign row_load = wr_nvm && row_mode_reg
        && (!row_held_reg || offs[5:3] == row_addr_reg);
    assign start_go = wr_ctl && bus.wdata[bec_pkg::CTL_START_BIT]
        && bus.wdata[bec_pkg::CTL_ENA_BIT]
        && bus.wdata[bec_pkg::CTL_ROWMODE_BIT] && row_mode_reg;
    assign row_enter = wr_ctl && bus.wdata[bec_pkg::CTL_ROWMODE_BIT]
        && !row_mode_reg;
    assign row_quit = wr_ctl && !bus.wdata[bec_pkg::CTL_ROWMODE_BIT];
    assign prog_done = busy_reg && prog_cnt_reg == 16'h0000;

    // Bank select: written only by an explicit store
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            bank_select_reg <= bec_pkg::BANK_RESET;
        else if (clk_en_in && bus.wr
            && bus.addr == bec_pkg::BANK_SEL_ADDR)
            bank_select_reg <= bus.wdata;
    end

    // Control bits; reserved bits are not stored
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            standby_reg <= bec_pkg::CTL_RESET[bec_pkg::CTL_STBY_BIT];
            prog_en_reg <= bec_pkg::CTL_RESET[bec_pkg::CTL_ENA_BIT];
            row_mode_reg <= bec_pkg::CTL_RESET[bec_pkg::CTL_ROWMODE_BIT];
            row_start_reg <= bec_pkg::CTL_RESET[bec_pkg::CTL_START_BIT];
        end
        else if (clk_en_in)
        begin
            if (prog_done && row_start_reg)
            begin
                row_mode_reg <= 1'b0;
                row_start_reg <= 1'b0;
            end
            else if (wr_ctl)
            begin
                standby_reg <= bus.wdata[bec_pkg::CTL_STBY_BIT];
                prog_en_reg <= bus.wdata[bec_pkg::CTL_ENA_BIT];
                row_mode_reg <= bus.wdata[bec_pkg::CTL_ROWMODE_BIT];
                row_start_reg <= start_go;
            end
        end
    end

    // Programming timer; busy stands for the whole cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            busy_reg <= 1'b0;
            prog_cnt_reg <= 16'h0000;
            row_cycle_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (byte_go || start_go)
            begin
                busy_reg <= 1'b1;
                prog_cnt_reg <= PROG_LAST;
                row_cycle_reg <= start_go;
            end
            else if (prog_done)
                busy_reg <= 1'b0;
            else if (busy_reg)
                prog_cnt_reg <= prog_cnt_reg - 16'h0001;
        end
    end

    // Byte held for programming at the end of the cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            byte_addr_reg <= 6'h00;
            byte_data_reg <= 8'h00;
        end
        else if (clk_en_in && byte_go)
        begin
            byte_addr_reg <= offs;
            byte_data_reg <= bus.wdata;
        end
    end

    // Row address capture on the first load after entry
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            row_held_reg <= 1'b0;
            row_addr_reg <= 3'h0;
        end
        else if (clk_en_in)
        begin
            if (row_enter || row_quit || prog_done)
                row_held_reg <= 1'b0;
            else if (row_load && !row_held_reg)
            begin
                row_held_reg <= 1'b1;
                row_addr_reg <= offs[5:3];
            end
        end
    end

    // Volatile row latches, one per byte of a row
    for (genvar i = 0; i < bec_pkg::ROW_BYTES; i++)
    begin : g_row
        always_ff @(posedge clk_sys_in)
        begin
            if (sys_rst_in)
            begin
                row_latch_reg[i] <= 8'h00;
                row_mask_reg[i] <= 1'b0;
            end
            else if (clk_en_in)
            begin
                if (row_enter)
                begin
                    row_latch_reg[i] <= 8'h00;
                    row_mask_reg[i] <= 1'b0;
                end
                else if (row_quit || (prog_done && row_cycle_reg))
                    row_mask_reg[i] <= 1'b0;
                else if (row_load && offs[2:0] == 3'(i))
                begin
                    row_latch_reg[i] <= bus.wdata;
                    row_mask_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Page storage; the arrays carry no reset, contents survive a reset
    for (genvar i = 0; i < bec_pkg::PAGE_BYTES; i++)
    begin : g_page
        always_ff @(posedge clk_sys_in)
        begin
            if (clk_en_in && wr_ram && offs == 6'(i))
                ram_reg[i] <= bus.wdata;
        end

        always_ff @(posedge clk_sys_in)
        begin
            if (clk_en_in && prog_done)
            begin
                if (row_cycle_reg)
                begin
                    if (row_mask_reg[i % 8] && row_addr_reg == 3'(i / 8))
                        nvm_reg[i] <= row_latch_reg[i % 8];
                end
                else if (byte_addr_reg == 6'(i))
                    nvm_reg[i] <= byte_data_reg;
            end
        end
    end

    // Read data, one cycle after the strobe and zero otherwise
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            rdata_reg <= 8'h00;
        else if (clk_en_in)
        begin
            rdata_reg <= 8'h00;
            if (bus.rd && in_bank && ram_sel)
                rdata_reg <= ram_reg[offs];
            else if (bus.rd && in_bank && nvm_live)
                rdata_reg <= nvm_reg[offs];
            else if (bus.rd && bus.addr == bec_pkg::NVM_CTL_ADDR)
                rdata_reg[bec_pkg::CTL_BUSY_BIT] <= busy_reg;
        end
    end

    assign bus.rdata = rdata_reg;
    assign nvm_busy_out = busy_reg;
    assign nvm_standby_out = standby_reg;
    assign bank_select_out = bank_select_reg;

endmodule

// ### design/bec_core_host.sv
/*
 * Core end: takes single data-space accesses from software through its own
 * small register file, issues them on the bus, keeps RAM images of the
 * write-only device registers and refuses accesses software must not make.
 * Assumes the device answers reads in the cycle after the strobe.
 */
module bec_core_host
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    bec_bus_if.host bus,
    input wire logic [2:0] usr_addr_in,
    input wire logic [7:0] usr_wdata_in,
    input wire logic usr_wr_in,
    input wire logic usr_rd_in,
    output logic [7:0] usr_rdata_out
);

    bec_pkg::bec_host_state_e state_reg;
    logic [7:0] addr_reg;
    logic [7:0] data_reg;
    logic [7:0] rdata_reg;
    logic [7:0] bank_img_reg;
    logic [7:0] ctl_img_reg;
    logic done_reg;
    logic refused_reg;
    logic [7:0] lk_addr_reg;
    logic [7:0] lk_wdata_reg;
    logic lk_wr_reg;
    logic lk_rd_reg;
    logic [7:0] usr_rdata_reg;

    logic cmd_wr;
    logic want_rd;
    logic want_wr;
    logic bad_bank;
    logic bad_read;
    logic accept;

    // Command decode and refusal checks
    assign cmd_wr = usr_wr_in && usr_addr_in == bec_pkg::H_CMD;
    assign want_rd = usr_wdata_in[bec_pkg::CMD_RD_BIT];
    assign want_wr = usr_wdata_in[bec_pkg::CMD_WR_BIT] && !want_rd;
    // More than one page bit would enable pages in parallel
    assign bad_bank = want_wr && addr_reg == bec_pkg::BANK_SEL_ADDR
        && data_reg[bec_pkg::RAM2_SEL_BIT]
        && data_reg[bec_pkg::NVM_SEL_BIT];
    // Reads of the page are unsafe while row mode is set
    assign bad_read = want_rd && addr_reg[7:6] == bec_pkg::BANK_REGION_TOP
        && bank_img_reg == bec_pkg::SEL_NVM
        && ctl_img_reg[bec_pkg::CTL_ROWMODE_BIT];
    assign accept = cmd_wr && state_reg == bec_pkg::BEC_IDLE
        && (want_rd || want_wr) && !bad_bank && !bad_read;

    // Software-facing address and data holding registers
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            addr_reg <= 8'h00;
            data_reg <= 8'h00;
        end
        else if (clk_en_in && usr_wr_in)
        begin
            if (usr_addr_in == bec_pkg::H_ADDR)
                addr_reg <= usr_wdata_in;
            if (usr_addr_in == bec_pkg::H_DATA)
                data_reg <= usr_wdata_in;
        end
    end

    // Images updated in the same cycle the write is launched
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            bank_img_reg <= bec_pkg::BANK_RESET;
            ctl_img_reg <= bec_pkg::CTL_RESET;
        end
        else if (clk_en_in && accept && want_wr)
        begin
            if (addr_reg == bec_pkg::BANK_SEL_ADDR)
                bank_img_reg <= data_reg;
            if (addr_reg == bec_pkg::NVM_CTL_ADDR)
                ctl_img_reg <= data_reg;
        end
    end

    // Access sequencer driving the bus from flops
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            state_reg <= bec_pkg::BEC_IDLE;
            lk_addr_reg <= 8'h00;
            lk_wdata_reg <= 8'h00;
            lk_wr_reg <= 1'b0;
            lk_rd_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else if (clk_en_in)
        begin
            unique case (state_reg)
                bec_pkg::BEC_IDLE:
                begin
                    if (accept)
                    begin
                        lk_addr_reg <= addr_reg;
                        lk_wdata_reg <= data_reg;
                        lk_wr_reg <= want_wr;
                        lk_rd_reg <= want_rd;
                        state_reg <= bec_pkg::BEC_ISSUE;
                    end
                end
                bec_pkg::BEC_ISSUE:
                begin
                    lk_wr_reg <= 1'b0;
                    lk_rd_reg <= 1'b0;
                    state_reg <= lk_rd_reg ? bec_pkg::BEC_CAPT
                        : bec_pkg::BEC_IDLE;
                end
                bec_pkg::BEC_CAPT:
                begin
                    rdata_reg <= bus.rdata;
                    state_reg <= bec_pkg::BEC_IDLE;
                end
                default:
                    state_reg <= bec_pkg::BEC_IDLE;
            endcase
        end
    end

    // Done and refused flags; an accepted command clears both, a refused one sets refused
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (accept)
            begin
                done_reg <= 1'b0;
                refused_reg <= 1'b0;
            end
            else if (cmd_wr)
                refused_reg <= 1'b1;
            if ((state_reg == bec_pkg::BEC_ISSUE && !lk_rd_reg)
                || state_reg == bec_pkg::BEC_CAPT)
                done_reg <= 1'b1;
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            usr_rdata_reg <= 8'h00;
        else if (clk_en_in)
        begin
            usr_rdata_reg <= 8'h00;
            if (usr_rd_in)
            begin
                unique case (usr_addr_in)
                    bec_pkg::H_ADDR: usr_rdata_reg <= addr_reg;
                    bec_pkg::H_DATA: usr_rdata_reg <= data_reg;
                    bec_pkg::H_STATUS:
                    begin
                        usr_rdata_reg[bec_pkg::ST_PEND_BIT] <=
                            state_reg != bec_pkg::BEC_IDLE;
                        usr_rdata_reg[bec_pkg::ST_DONE_BIT] <= done_reg;
                        usr_rdata_reg[bec_pkg::ST_REFUSED_BIT] <= refused_reg;
                    end
                    bec_pkg::H_RDATA: usr_rdata_reg <= rdata_reg;
                    bec_pkg::H_BANK_IMG: usr_rdata_reg <= bank_img_reg;
                    bec_pkg::H_CTL_IMG: usr_rdata_reg <= ctl_img_reg;
                    default: usr_rdata_reg <= 8'h00;
                endcase
            end
        end
    end

    assign bus.addr = lk_addr_reg;
    assign bus.wdata = lk_wdata_reg;
    assign bus.wr = lk_wr_reg;
    assign bus.rd = lk_rd_reg;
    assign usr_rdata_out = usr_rdata_reg;

endmodule

// ### tb/bec_bus_monitor.sv
/*
 * Checker for the data-space bus joining the core end and device end.
 * Assumes one clock, clock enable dropped only while the bus is quiet,
 * synchronous active-high reset.
 */
module bec_bus_monitor
#(
    parameter int unsigned PROG_CYCLES = bec_pkg::PROG_CYCLES
)
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic nvm_busy_out,
    input wire logic nvm_standby_out,
    input wire logic [7:0] bank_select_out
);
    logic [15:0] busy_cnt_reg;

    // Length of the current busy run; wide so a stuck flag cannot wrap
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || !nvm_busy_out)
            busy_cnt_reg <= 16'h0000;
        else if (clk_en_in)
            busy_cnt_reg <= busy_cnt_reg + 16'h0001;
    end

    default clocking mon_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    // Accesses to the two device registers
    sequence s_bank_wr;
        clk_en_in && wr && addr == bec_pkg::BANK_SEL_ADDR;
    endsequence
    sequence s_ctl_wr;
        clk_en_in && wr && addr == bec_pkg::NVM_CTL_ADDR;
    endsequence
    sequence s_ctl_rd;
        clk_en_in && rd && addr == bec_pkg::NVM_CTL_ADDR;
    endsequence

    AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not idle");
    AST_BANK_RD: assert property (
        rd && addr == bec_pkg::BANK_SEL_ADDR |=> rdata == 8'h00)
        else $error("bank select read not blank");
    AST_BANK_WR: assert property (
        s_bank_wr |=> bank_select_out == $past(wdata))
        else $error("bank select not loaded");
    AST_BANK_HOLD: assert property (
        !(wr && addr == bec_pkg::BANK_SEL_ADDR) |=> $stable(bank_select_out))
        else $error("bank select changed without write");
    AST_PROG_CAUSE: assert property (
        $rose(nvm_busy_out) |-> $past(wr))
        else $error("busy rose without write");
    AST_PROG_GATE: assert property (
        $rose(nvm_busy_out) |-> $past(bank_select_out) == bec_pkg::SEL_NVM
        && !$past(nvm_standby_out))
        else $error("programming while page off");
    AST_BUSY_LEN: assert property (
        $fell(nvm_busy_out) |-> busy_cnt_reg == PROG_CYCLES)
        else $error("busy length wrong");
    AST_CTL_LOCK: assert property (
        s_ctl_wr ##0 nvm_busy_out |=> $stable(nvm_standby_out))
        else $error("control written while busy");
    AST_STBY_SET: assert property (
        s_ctl_wr ##0 !nvm_busy_out |=>
        nvm_standby_out == (($past(wdata) & 8'h40) != 8'h00))
        else $error("standby bit not loaded");
    AST_BUSY_RD: assert property (
        s_ctl_rd |=> rdata == {6'h00, $past(nvm_busy_out), 1'b0})
        else $error("control read wrong");
endmodule

// ### tb/banked_eeprom_access_control_bench.sv
/*
 * Bench for the banked page and nonvolatile write pair: drives the core
 * end's register port and checks reads, busy, standby and bank outputs.
 * Assumes package, bus interface, both ends and the monitor compiled first.
 */
module banked_eeprom_access_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Short programming cycle, still long enough to probe while busy
    localparam int unsigned PROG_LEN = 100;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic [2:0] usr_addr_in = 3'h0;
    logic [7:0] usr_wdata_in = 8'h00;
    logic usr_wr_in = 1'b0;
    logic usr_rd_in = 1'b0;
    logic [7:0] usr_rdata_out;
    logic nvm_busy_out;
    logic nvm_standby_out;
    logic [7:0] bank_select_out;
    logic [7:0] rv;
    logic [7:0] nomap [2] = '{8'h00, 8'h02};
    logic [7:0] row_a [5] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h20};
    logic [7:0] row_d [5] = '{8'h99, 8'h77, 8'h22, 8'h33, 8'h66};
    int fails = 0;
    int tests_run = 0;

    bec_bus_if bec_bus_if_inst();

    bec_nvm_dev #(.PROG_CYCLES(PROG_LEN)) bec_nvm_dev_inst
    (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .bus(bec_bus_if_inst),
        .nvm_busy_out(nvm_busy_out),
        .nvm_standby_out(nvm_standby_out),
        .bank_select_out(bank_select_out)
    );

    bec_core_host bec_core_host_inst
    (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .bus(bec_bus_if_inst),
        .usr_addr_in(usr_addr_in),
        .usr_wdata_in(usr_wdata_in),
        .usr_wr_in(usr_wr_in),
        .usr_rd_in(usr_rd_in),
        .usr_rdata_out(usr_rdata_out)
    );

    bec_bus_monitor #(.PROG_CYCLES(PROG_LEN)) bec_bus_monitor_inst
    (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .addr(bec_bus_if_inst.addr),
        .wdata(bec_bus_if_inst.wdata),
        .wr(bec_bus_if_inst.wr),
        .rd(bec_bus_if_inst.rd),
        .rdata(bec_bus_if_inst.rdata),
        .nvm_busy_out(nvm_busy_out),
        .nvm_standby_out(nvm_standby_out),
        .bank_select_out(bank_select_out)
    );

    // 50 MHz system clock
    always #10 clk_sys_in = ~clk_sys_in;

    task automatic chk(input string n, input logic [7:0] got,
        input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", n, exp, got);
            fails++;
        end
    endtask

    task automatic close_out();
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Controller register port: one-cycle strobes, a free edge between
    task automatic uw(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        usr_addr_in <= a;
        usr_wdata_in <= d;
        usr_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        usr_wr_in <= 1'b0;
    endtask

    task automatic ur(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        usr_addr_in <= a;
        usr_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        usr_rd_in <= 1'b0;
        #1 d = usr_rdata_out;
    endtask

    // One data-space access; waits for done, or checks the refusal flag
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [7:0] d, input logic refd);
        logic [7:0] s;
        uw(bec_pkg::H_ADDR, a);
        uw(bec_pkg::H_DATA, d);
        uw(bec_pkg::H_CMD, w ? 8'h02 : 8'h01);
        s = 8'h00;
        if (refd)
        begin
            ur(bec_pkg::H_STATUS, s);
            chk("refused", s & 8'h04, 8'h04);
        end
        else
        begin
            for (int i = 0; i < 20 && s[1:0] !== 2'b10; i++)
                ur(bec_pkg::H_STATUS, s);
            chk("done", s & 8'h03, 8'h02);
            if (!w)
                ur(bec_pkg::H_RDATA, rv);
        end
    endtask

    task automatic wrd(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 1'b0);
    endtask

    task automatic rdc(input string n, input logic [7:0] a,
        input logic [7:0] e);
        acc(1'b0, a, 8'h00, 1'b0);
        chk(n, rv, e);
    endtask

    task automatic busy_is(input logic e);
        chk("busy", {7'h00, nvm_busy_out}, {7'h00, e});
    endtask

    // Bounded wait for the programming cycle to end
    task automatic idle();
        for (int i = 0; i < 300 && nvm_busy_out !== 1'b0; i++)
        begin
            @(posedge clk_sys_in);
            #1;
        end
        busy_is(1'b0);
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
    end

    // Watchdog well beyond the thousand or so cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        fails++;
        close_out();
    end

    initial
    begin
        @(negedge sys_rst_in);
        chk("bank_rst", bank_select_out, bec_pkg::BANK_RESET);
        rdc("ctl_rst", bec_pkg::NVM_CTL_ADDR, bec_pkg::CTL_RESET);
        // Second RAM page, write-only bank register, two-bit code refused
        wrd(bec_pkg::BANK_SEL_ADDR, bec_pkg::SEL_RAM2);
        chk("bank", bank_select_out, bec_pkg::SEL_RAM2);
        wrd(8'h05, 8'h5a);
        rdc("ram2", 8'h05, 8'h5a);
        rdc("bank_rd", bec_pkg::BANK_SEL_ADDR, 8'h00);
        acc(1'b1, bec_pkg::BANK_SEL_ADDR, 8'h11, 1'b1);
        chk("bank_keep", bank_select_out, bec_pkg::SEL_RAM2);
        // Image follows the accepted store, not the refused one
        ur(bec_pkg::H_BANK_IMG, rv);
        chk("bank_img", rv, bec_pkg::SEL_RAM2);
        // Empty and reserved codes map nothing and never program
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h01);
        foreach (nomap[i])
        begin
            wrd(bec_pkg::BANK_SEL_ADDR, nomap[i]);
            wrd(8'h05, 8'h3c);
            busy_is(1'b0);
            rdc("nomap", 8'h05, 8'h00);
        end
        // Byte mode, with probes while the cycle runs
        wrd(bec_pkg::BANK_SEL_ADDR, bec_pkg::SEL_NVM);
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h00);
        wrd(8'h05, 8'haa);
        busy_is(1'b0);
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h01);
        wrd(8'h05, 8'haa);
        busy_is(1'b1);
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h40);
        chk("stby_lock", {7'h00, nvm_standby_out}, 8'h00);
        rdc("busy_rd", bec_pkg::NVM_CTL_ADDR, 8'h02);
        wrd(8'h05, 8'h00);
        idle();
        rdc("byte", 8'h05, 8'haa);
        wrd(8'h19, 8'h77);
        idle();
        wrd(8'h20, 8'h66);
        idle();
        // Standby voids the page; start without row mode is dropped
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h41);
        chk("stby", {7'h00, nvm_standby_out}, 8'h01);
        ur(bec_pkg::H_CTL_IMG, rv);
        chk("ctl_img", rv, 8'h41);
        wrd(8'h05, 8'h11);
        busy_is(1'b0);
        rdc("stby_rd", 8'h05, 8'h00);
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h09);
        busy_is(1'b0);
        // Abandoned row, then a fresh row with a stray load outside it
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h05);
        wrd(8'h19, 8'h55);
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h01);
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h05);
        acc(1'b0, 8'h18, 8'h00, 1'b1);
        for (int i = 2; i < 4; i++)
            wrd(row_a[i], row_d[i]);
        wrd(8'h20, 8'h44);
        busy_is(1'b0);
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h0d);
        busy_is(1'b1);
        idle();
        // Row mode gone after the cycle, so this programs one byte
        wrd(8'h18, 8'h99);
        busy_is(1'b1);
        // Clock enable low must freeze the timer past its normal end
        @(posedge clk_sys_in);
        clk_en_in <= 1'b0;
        repeat (150) @(posedge clk_sys_in);
        busy_is(1'b1);
        clk_en_in <= 1'b1;
        idle();
        wrd(bec_pkg::NVM_CTL_ADDR, 8'h01);
        foreach (row_a[i])
            rdc("row", row_a[i], row_d[i]);
        close_out();
    end
endmodule
